// *** verilog/hbc_pkg.sv ***
package hbc_pkg;
    // Clock figures
    localparam int CLK_PERIOD_NS = 25;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CURR = 8'h04;
    localparam logic [7:0] OFS_VOLT = 8'h08;
    localparam logic [7:0] OFS_DAC = 8'h0C;
    localparam logic [7:0] OFS_FILT = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    localparam int STAT_FAULT_BIT = 4;
    // Values after reset
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] UCUR_RST = 8'hC0;
    localparam logic [7:0] LCUR_RST = 8'h40;
    localparam logic [7:0] FCUR_RST = 8'hF0;
    localparam logic [7:0] UVOLT_RST = 8'hB0;
    localparam logic [7:0] LVOLT_RST = 8'hA0;
    localparam logic [7:0] FILT_RST = 8'h0A;
    // Converter phase
    typedef enum logic [1:0] {HBC_IDLE, HBC_ASYNC, HBC_SYNC} hbc_phase_type;
endpackage

// *** verilog/hbc_filt_if.sv ***
`timescale 1ns/1ps
interface hbc_filt_if;
    logic raw;       // Synchronised comparator level
    logic restart;   // Pulse: threshold changed, restart filtering
    logic [7:0] time_us; // Filter length in microseconds
    logic level;     // Filtered comparator level
    modport filt (input raw, input restart, input time_us, output level);
    modport ctrl (output raw, output restart, output time_us, input level);
endinterface

// *** verilog/hbc_filter.sv ***
`timescale 1ns/1ps
module hbc_filter
    import hbc_pkg::*;
(
    input wire logic pclk,     // System clock
    input wire logic presetn,  // Async reset, active low
    hbc_filt_if.filt fb        // Feedback filter port
);
    logic [5:0] pre_reg;   // Microsecond prescaler
    logic [7:0] cnt_reg;   // Microseconds of stable mismatch
    logic tick;            // One cycle per microsecond
    logic lvl_reg;         // Filtered level

    assign tick = (pre_reg == 6'(CYC_PER_US - 1));
    assign fb.level = lvl_reg;

    ////////////////////////////////////////////////////////////////
    // Microsecond prescaler, held at zero while nothing is filtered
    // A free running one would cut the first microsecond short
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_reg <= 6'h00;
        else if (tick || fb.restart || fb.raw == lvl_reg)
            pre_reg <= 6'h00;
        else
            pre_reg <= pre_reg + 6'h01;
    end

    ////////////////////////////////////////////////////////////////
    // Level accepted only after it held for the programmed time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 8'h00;
            lvl_reg <= 1'b0;
        end
        else if (fb.restart || fb.raw == lvl_reg)
            cnt_reg <= 8'h00;
        else if (cnt_reg >= fb.time_us)
        begin
            lvl_reg <= fb.raw;
            cnt_reg <= 8'h00;
        end
        else if (tick)
            cnt_reg <= cnt_reg + 8'h01;
    end
endmodule

// *** verilog/hbc_top.sv ***
`timescale 1ns/1ps
module hbc_top
    import hbc_pkg::*;
(
    input wire logic pclk,             // 40 MHz system clock
    input wire logic presetn,          // Async reset, active low
    input wire logic psel,             // APB select
    input wire logic penable,          // APB enable
    input wire logic pwrite,           // APB direction
    input wire logic [7:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,    // APB write data
    output logic [31:0] prdata,        // APB read data
    output logic pready,               // APB ready
    output logic pslverr,              // APB error, unmapped address
    input wire logic cur_over_upper,   // Pin: current above upper limit
    input wire logic cur_under_lower,  // Pin: current below lower limit
    input wire logic cur_over_fault,   // Pin: current above fault limit
    input wire logic volt_fb_above,    // Pin: boost voltage above threshold
    input wire logic core_async_en,    // Core: hardware switching enable
    input wire logic core_dac_wr,      // Core: threshold write strobe
    input wire logic [7:0] core_dac_data, // Core: threshold value
    output logic boost_switch_driver,  // Low side switch gate
    output logic [7:0] boost_threshold_converter, // Voltage threshold code
    output logic [7:0] upper_current_limit, // Current threshold code
    output logic [7:0] lower_current_limit, // Current threshold code
    output logic [7:0] fault_current_limit, // Current threshold code
    output logic wait_under_evt,       // Pulse: voltage fell below
    output logic wait_over_evt         // Pulse: voltage rose above
);
    ////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0] ctrl_reg;          // Enable and auto alternation
    logic [7:0] ucur_reg;          // Upper current code
    logic [7:0] lcur_reg;          // Lower current code
    logic [7:0] fcur_reg;          // Fault current code
    logic [7:0] uvolt_reg;         // Upper voltage code
    logic [7:0] lvolt_reg;         // Lower voltage code
    logic [7:0] dac_reg;           // Threshold driven out
    logic [7:0] filt_reg;          // Filter time in microseconds
    logic fault_reg;               // Sticky fault seen
    logic [3:0] s1_reg;            // First synchroniser stage
    logic [3:0] s2_reg;            // Second synchroniser stage
    hbc_phase_type phase_reg;      // Converter phase
    hbc_phase_type phase_next;     // Next phase
    logic sw_reg;                  // Switch state
    logic lvl_d_reg;               // Filtered level, one cycle late
    logic restart_reg;             // Filter restart pulse
    logic under_reg;               // Under event register
    logic over_reg;                // Over event register
    logic [31:0] rd_reg;           // Read data register
    logic rdy_reg;                 // Ready register
    logic err_reg;                 // Error register
    logic hw_en;                   // Switching enabled
    logic wr_acc;                  // Write in access phase
    logic mapped;                  // Address decodes
    logic [31:0] rd_mux;           // Read data selection

    hbc_filt_if fbi ();

    assign prdata = rd_reg;
    assign pready = rdy_reg;
    assign pslverr = err_reg;
    assign boost_switch_driver = sw_reg;
    assign boost_threshold_converter = dac_reg;
    assign upper_current_limit = ucur_reg;
    assign lower_current_limit = lcur_reg;
    assign fault_current_limit = fcur_reg;
    assign wait_under_evt = under_reg;
    assign wait_over_evt = over_reg;

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers; only s2 feeds logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
        end
        else
        begin
            s1_reg <= {volt_fb_above, cur_over_fault, cur_under_lower, cur_over_upper};
            s2_reg <= s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Voltage feedback filter
    assign fbi.raw = s2_reg[3];
    assign fbi.restart = restart_reg;
    assign fbi.time_us = filt_reg;

    hbc_filter u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .fb(fbi.filt)
    );

    ////////////////////////////////////////////////////////////////
    // APB decode; zero wait states, answer in the access cycle
    assign wr_acc = psel && penable && pwrite && rdy_reg;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CURR) || (paddr == OFS_VOLT)
        || (paddr == OFS_DAC) || (paddr == OFS_FILT) || (paddr == OFS_STAT);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: rd_mux = {30'h0, ctrl_reg};
            OFS_CURR: rd_mux = {8'h00, fcur_reg, lcur_reg, ucur_reg};
            OFS_VOLT: rd_mux = {16'h0000, lvolt_reg, uvolt_reg};
            OFS_DAC: rd_mux = {24'h000000, dac_reg};
            OFS_FILT: rd_mux = {24'h000000, filt_reg};
            OFS_STAT: rd_mux = {27'h0, fault_reg, fbi.level, sw_reg, phase_reg};
            default: rd_mux = 32'h0000_0000; // Unmapped reads as zero
        endcase
    end

    // Ready, error and read data set up during the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
        end
        else
        begin
            rdy_reg <= psel && !penable;
            err_reg <= psel && !penable && !mapped;
            rd_reg <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Software configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RST;
            ucur_reg <= UCUR_RST;
            lcur_reg <= LCUR_RST;
            fcur_reg <= FCUR_RST;
            uvolt_reg <= UVOLT_RST;
            lvolt_reg <= LVOLT_RST;
            filt_reg <= FILT_RST;
        end
        else if (wr_acc)
        begin
            unique case (paddr)
                OFS_CTRL: ctrl_reg <= pwdata[1:0];
                OFS_CURR:
                begin
                    ucur_reg <= pwdata[7:0];
                    lcur_reg <= pwdata[15:8];
                    fcur_reg <= pwdata[23:16];
                end
                OFS_VOLT:
                begin
                    uvolt_reg <= pwdata[7:0];
                    lvolt_reg <= pwdata[15:8];
                end
                OFS_FILT: filt_reg <= pwdata[7:0];
                default: ; // DAC and STAT written in their own blocks, or unmapped
            endcase
        end
    end

    // Sticky fault: a new fault wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_reg <= 1'b0;
        else if (s2_reg[2])
            fault_reg <= 1'b1;
        else if (wr_acc && paddr == OFS_STAT && pwdata[STAT_FAULT_BIT])
            fault_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Phase control
    // Manual mode follows the core enable; auto mode alternates itself
    assign hw_en = ctrl_reg[CTRL_EN_BIT] && (ctrl_reg[CTRL_AUTO_BIT] || core_async_en);

    always_comb
    begin
        phase_next = phase_reg;
        unique case (phase_reg)
            HBC_IDLE:
                if (hw_en)
                    phase_next = HBC_ASYNC;
            HBC_ASYNC:
                if (!hw_en)
                    phase_next = HBC_IDLE;
                else if (fbi.level && !restart_reg)
                    phase_next = HBC_SYNC;
            HBC_SYNC:
                if (!hw_en)
                    phase_next = HBC_IDLE;
                else if (!fbi.level && !restart_reg && ctrl_reg[CTRL_AUTO_BIT])
                    phase_next = HBC_ASYNC;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= HBC_IDLE;
        else
            phase_reg <= phase_next;
    end

    // In auto mode threshold loaded on each phase change; filter restarts after it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dac_reg <= UVOLT_RST;
            restart_reg <= 1'b0;
        end
        else if (ctrl_reg[CTRL_AUTO_BIT] && phase_next != phase_reg)
        begin
            dac_reg <= (phase_next == HBC_SYNC) ? lvolt_reg : uvolt_reg;
            restart_reg <= 1'b1;
        end
        else if (wr_acc && paddr == OFS_DAC)
        begin
            dac_reg <= pwdata[7:0];
            restart_reg <= 1'b1;
        end
        else if (core_dac_wr)
        begin
            dac_reg <= core_dac_data;
            restart_reg <= 1'b1;
        end
        else
            restart_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Hysteretic switch; frequency set only by comparator crossings
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sw_reg <= 1'b0;
        else if (phase_next != HBC_ASYNC || s2_reg[2])
            sw_reg <= 1'b0;
        else if (phase_reg != HBC_ASYNC)
            sw_reg <= 1'b1;
        else if (sw_reg && s2_reg[0])
            sw_reg <= 1'b0;
        else if (!sw_reg && s2_reg[1])
            sw_reg <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // Wait-table events on filtered feedback edges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl_d_reg <= 1'b0;
            under_reg <= 1'b0;
            over_reg <= 1'b0;
        end
        else
        begin
            lvl_d_reg <= fbi.level;
            under_reg <= lvl_d_reg && !fbi.level;
            over_reg <= !lvl_d_reg && fbi.level;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    AST_SW_OFF_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == HBC_ASYNC && sw_reg && s2_reg[0]) |=> !sw_reg)
        else $error("Switch stayed on above upper current");
    AST_SW_ON_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == HBC_ASYNC && phase_next == HBC_ASYNC && !sw_reg && s2_reg[1]
        && !s2_reg[2]) |=> sw_reg)
        else $error("Switch stayed off below lower current");
    AST_SYNC_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == HBC_SYNC) |-> !sw_reg)
        else $error("Switch on in sync phase");
    AST_TO_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == HBC_ASYNC && hw_en && fbi.level && !restart_reg)
        |=> phase_reg == HBC_SYNC)
        else $error("Async phase did not end on overvoltage");
    AST_BACK_ASYNC: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_reg == HBC_SYNC && hw_en && ctrl_reg[CTRL_AUTO_BIT] && !fbi.level
        && !restart_reg) |=> phase_reg == HBC_ASYNC)
        else $error("Sync phase did not return to async");
    AST_DAC_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg[CTRL_AUTO_BIT] && phase_reg == HBC_ASYNC && phase_next == HBC_SYNC)
        |=> dac_reg == $past(lvolt_reg) && restart_reg)
        else $error("Lower threshold not loaded on sync entry");
    AST_EVT_OVER: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fbi.level) |=> over_reg ##1 !over_reg)
        else $error("Over event not a single pulse");
    // Switch and phase both drop at once; a re-enable may follow at once
    AST_DISABLE: assert property (@(posedge pclk) disable iff (!presetn)
        !hw_en |=> phase_reg == HBC_IDLE && !sw_reg)
        else $error("Switching not stopped when disabled");
    AST_CORE_DAC: assert property (@(posedge pclk) disable iff (!presetn)
        (core_dac_wr && !(wr_acc && paddr == OFS_DAC) && phase_next == phase_reg)
        |=> dac_reg == $past(core_dac_data))
        else $error("Core threshold write lost");
endmodule

// *** sim/hbc_boost_plant.sv ***
`timescale 1ns/1ps
// Inductor, switch, shunt and boost capacitor, in limit-code units
module hbc_boost_plant
    import hbc_pkg::*;
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic boost_switch_driver, // Gate, high = on
    input wire logic [7:0] upper_current_limit, // Upper current code
    input wire logic [7:0] lower_current_limit, // Lower current code
    input wire logic [7:0] fault_current_limit, // Fault current code
    input wire logic [7:0] boost_threshold_converter, // Voltage threshold
    input wire logic fault_force, // Bench: forced fault reading
    output logic cur_over_upper, // Current above upper
    output logic cur_under_lower, // Current below lower
    output logic cur_over_fault, // Current above fault
    output logic volt_fb_above, // Voltage above threshold
    output logic [7:0] cur_code, // Inductor current
    output logic [7:0] volt_code // Boost voltage
);
    logic [11:0] volt_reg; // Fine voltage, 16 steps a code
    logic [2:0] drain_reg; // Load drain prescaler
    ////////////////////////////////////////////////////////////
    // Ramps up while on, decays through the diode while off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_code <= 8'h00;
        else if (boost_switch_driver && cur_code != 8'hFF)
            cur_code <= cur_code + 8'h01;
        else if (!boost_switch_driver && cur_code != 8'h00)
            cur_code <= cur_code - 8'h01;
    end
    // Diode current charges, a slow load drains; in sync only the decaying current charges
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            volt_reg <= 12'h000;
            drain_reg <= 3'h0;
        end
        else
        begin
            drain_reg <= drain_reg + 3'h1;
            if (!boost_switch_driver && cur_code != 8'h00)
                volt_reg <= volt_reg + 12'h001;
            else if (drain_reg == 3'h7 && volt_reg != 12'h000)
                volt_reg <= volt_reg - 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////
    // Ideal comparators; the design does its own synchronising
    assign volt_code = volt_reg[11:4];
    assign cur_over_upper = cur_code > upper_current_limit;
    assign cur_under_lower = cur_code < lower_current_limit;
    assign cur_over_fault = fault_force || (cur_code > fault_current_limit);
    assign volt_fb_above = volt_code > boost_threshold_converter;
endmodule

// *** sim/hbc_top_bench.sv ***
`timescale 1ns/1ps
module hbc_top_bench;
    import hbc_pkg::*;
    logic pclk = 1'b0; // Bus clock
    logic presetn = 1'b0; // Reset, active low
    logic psel = 1'b0; // APB select
    logic penable = 1'b0; // APB enable
    logic pwrite = 1'b0; // APB direction
    logic [7:0] paddr = 8'h00; // APB address
    logic [31:0] pwdata = 32'h0; // APB write data
    logic [31:0] prdata; // APB read data
    logic pready; // APB ready
    logic pslverr; // APB error
    logic cur_over_upper; // Plant comparator
    logic cur_under_lower; // Plant comparator
    logic cur_over_fault; // Plant comparator
    logic volt_fb_above; // Plant comparator
    logic core_async_en = 1'b0; // Core switching enable
    logic core_dac_wr = 1'b0; // Core threshold strobe
    logic [7:0] core_dac_data = 8'h00; // Core threshold value
    logic boost_switch_driver; // Gate drive
    logic [7:0] boost_threshold_converter; // Voltage threshold
    logic [7:0] upper_current_limit; // Current code
    logic [7:0] lower_current_limit; // Current code
    logic [7:0] fault_current_limit; // Current code
    logic wait_under_evt; // Event pulse
    logic wait_over_evt; // Event pulse
    logic fault_force = 1'b0; // Forced fault reading
    logic [7:0] cur_code; // Plant current
    logic [7:0] volt_code; // Plant voltage
    int failures = 0; // Mismatches
    int check_count = 0; // Comparisons
    int cyc = 0; // Cycle count
    int last_fb = 0; // Cycle of last raw feedback edge
    int on_count = 0; // Switch turn-ons
    int early_off = 0; // Turn-offs at or below the upper limit
    int n; // Wait length
    bit watch = 1'b0; // Current-level checks armed
    logic sw_q = 1'b0; // Switch at last edge
    logic fb_q = 1'b0; // Raw feedback at last edge
    logic [7:0] rst_ofs [6] = '{OFS_CTRL, OFS_CURR, OFS_VOLT, OFS_DAC, OFS_FILT, OFS_STAT};
    logic [31:0] rst_val [6] = '{32'h0, {8'h00, FCUR_RST, LCUR_RST, UCUR_RST},
        {16'h0, LVOLT_RST, UVOLT_RST}, 32'hB0, {24'h0, FILT_RST}, 32'h0};
    ////////////////////////////////////////////////////////////
    always #(CLK_PERIOD_NS / 2.0) pclk = ~pclk;
    hbc_top u_hbc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cur_over_upper(cur_over_upper), .cur_under_lower(cur_under_lower),
        .cur_over_fault(cur_over_fault), .volt_fb_above(volt_fb_above),
        .core_async_en(core_async_en), .core_dac_wr(core_dac_wr), .core_dac_data(core_dac_data),
        .boost_switch_driver(boost_switch_driver),
        .boost_threshold_converter(boost_threshold_converter),
        .upper_current_limit(upper_current_limit), .lower_current_limit(lower_current_limit),
        .fault_current_limit(fault_current_limit), .wait_under_evt(wait_under_evt),
        .wait_over_evt(wait_over_evt));
    hbc_boost_plant u_hbc_boost_plant (.pclk(pclk), .presetn(presetn),
        .boost_switch_driver(boost_switch_driver), .upper_current_limit(upper_current_limit),
        .lower_current_limit(lower_current_limit), .fault_current_limit(fault_current_limit),
        .boost_threshold_converter(boost_threshold_converter), .fault_force(fault_force),
        .cur_over_upper(cur_over_upper), .cur_under_lower(cur_under_lower),
        .cur_over_fault(cur_over_fault), .volt_fb_above(volt_fb_above),
        .cur_code(cur_code), .volt_code(volt_code));
    ////////////////////////////////////////////////////////////
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
        check_count++;
        if (got < lo || got > hi)
        begin
            failures++;
            $display("CHECK FAILED t=%0t %s %0d not in %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask
    // One transfer; entered just after an edge, leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        chk32({31'h0, pready}, 32'h1, "pready");
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eexp);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
        chk32({31'h0, e}, {31'h0, eexp}, "write error flag");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
        input logic eexp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk32(q & m, exp, "read data");
        chk32({31'h0, e}, {31'h0, eexp}, "read error flag");
    endtask
    // Bounded wait: 0 under event, 1 over event, 2 switch on
    task automatic wait_for(input int sel, input int lim);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while ((sel == 0 ? wait_under_evt : sel == 1 ? wait_over_evt : boost_switch_driver)
            !== 1'b1 && n < lim);
        chk_rng(n, 1, lim - 1, "wait length");
    endtask
    task automatic close_out();
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Switch edges against current, raw feedback edge times
    always @(posedge pclk)
    begin
        cyc++;
        if (volt_fb_above !== fb_q)
            last_fb = cyc;
        if (watch && sw_q === 1'b1 && boost_switch_driver === 1'b0)
        begin
            chk_rng(cur_code, 0, 8'h36, "off level");
            if (cur_code <= 8'h30)
                early_off++;
        end
        if (sw_q === 1'b0 && boost_switch_driver === 1'b1)
        begin
            on_count++;
            if (watch)
                chk_rng(cur_code, 0, 8'h0F, "on level");
        end
        sw_q = boost_switch_driver;
        fb_q = volt_fb_above;
    end
    // Hang guard, far beyond the expected few thousand cycles
    initial
    begin
        repeat (60000) @(posedge pclk);
        failures++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        close_out();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++)
            rd(rst_ofs[i], 32'hFFFFFFFF, rst_val[i], 1'b0);
        chk32({24'h0, boost_threshold_converter}, 32'hB0, "threshold after reset");
        rd(8'h18, 32'hFFFFFFFF, 32'h0, 1'b1);
        wr(8'h1C, 32'h5A, 1'b1);
        wr(OFS_CURR, 32'h00601030, 1'b0);
        wr(OFS_VOLT, 32'h00001820, 1'b0);
        wr(OFS_FILT, 32'h2, 1'b0);
        chk32({8'h00, upper_current_limit, lower_current_limit, fault_current_limit},
            32'h00301060, "current limits");
        wr(OFS_DAC, 32'h44, 1'b0);
        chk32({24'h0, boost_threshold_converter}, 32'h44, "host threshold");
        // Auto: regulate current, then hold off, then back again
        watch = 1'b1;
        on_count = 0;
        wr(OFS_CTRL, 32'h3, 1'b0);
        wait_for(1, 20000);
        chk_rng(cyc - last_fb, 82, 128, "filter span");
        chk_rng(on_count, 8, 10000, "switching cycles");
        chk_rng(early_off, 0, 1, "early turn-off");
        watch = 1'b0;
        rd(OFS_STAT, 32'h0F, 32'h0A, 1'b0);
        rd(OFS_DAC, 32'hFF, 32'h18, 1'b0);
        on_count = 0;
        wait_for(0, 20000);
        chk_rng(on_count, 0, 1, "switching in sync");
        chk_rng(volt_code, 0, 8'h18, "voltage at sync end");
        rd(OFS_STAT, 32'h0B, 32'h01, 1'b0);
        chk32({24'h0, boost_threshold_converter}, 32'h20, "upper reloaded");
        // Manual: the bench plays the core sequence
        wr(OFS_CTRL, 32'h1, 1'b0);
        core_dac_data <= 8'h1C;
        core_dac_wr <= 1'b1;
        @(posedge pclk);
        core_dac_wr <= 1'b0;
        repeat (3 * CYC_PER_US) @(posedge pclk);
        chk32({24'h0, boost_threshold_converter}, 32'h1C, "core threshold");
        on_count = 0;
        core_async_en <= 1'b1;
        wait_for(1, 20000);
        chk_rng(on_count, 2, 10000, "manual switching");
        rd(OFS_STAT, 32'h07, 32'h02, 1'b0);
        core_async_en <= 1'b0;
        on_count = 0;
        wait_for(0, 20000);
        chk_rng(on_count, 0, 0, "switch while disabled");
        // Fault comparator forces the switch off and latches
        wr(OFS_CTRL, 32'h3, 1'b0);
        wait_for(2, 200);
        fault_force <= 1'b1;
        repeat (5) @(posedge pclk);
        chk32({31'h0, boost_switch_driver}, 32'h0, "switch on fault");
        fault_force <= 1'b0;
        rd(OFS_STAT, 32'h10, 32'h10, 1'b0);
        wr(OFS_STAT, 32'h10, 1'b0);
        rd(OFS_STAT, 32'h10, 32'h00, 1'b0);
        close_out();
    end
endmodule
